// [core/lmfc_top.sv]
// lin master frame completion, checksum and write protect over ahb-lite
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - in length mode, identifier bits 5:4 give 2, 2, 4 or 8 response bytes
// - checksum is the inverted eight-bit sum with carries folded back in
// - type select one: classic checksum over data bytes only
// - type select zero: enhanced checksum also covers the protected identifier
// - checksum disable: no checksum; software sends the last byte as data
// - with auto checksum, no transmit ready after the last data byte write
// - frame slot mode is on unless frame slot disable is one
// - in slot mode transmit ready stays low until the slot time elapses
// - frame complete sets right after the checksum byte, not slot end
// - writing the status reset command clears frame complete
// - minimum slot follows maximum frame time, header taken as 34 bits
// - protect enable changes only with the right key; key reads zero
// - protect enable blocks writes to mode, baud, timeout and timeguard
module lmfc_top (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // byte stream to the line shifter
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  // status
  output logic transmit_ready_out,
  output logic irq_out
);
  // ****************************************
  // functions
  // ****************************************
  function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    csum_add = s[7:0] + {7'h00, s[8]};
  endfunction

  function automatic logic [3:0] id_len(input logic [1:0] idb);
    case (idb)
      2'h2: id_len = 4'h4;
      2'h3: id_len = 4'h8;
      default: id_len = 4'h2;
    endcase
  endfunction

  function automatic logic [15:0] slot_bits(input logic [3:0] n);
    logic [15:0] frame;
    frame = lmfc_pkg::HDR_BITS + lmfc_pkg::BYTE_BITS * ({12'h000, n} + 16'h0001);
    slot_bits = (frame * lmfc_pkg::SLOT_NUM + lmfc_pkg::SLOT_DEN - 16'h0001) / lmfc_pkg::SLOT_DEN;
  endfunction

  // ****************************************
  // state
  // ****************************************
  lmfc_pkg::lmfc_state_t st_r, st_nxt;
  lmfc_pkg::lmfc_mode_t mode_r;
  logic a_wr_r;
  logic [7:0] a_addr_r;
  logic [31:0] hrdata_r;
  logic [15:0] baud_r, rto_r;
  logic [7:0] ttg_r, id_r, hold_r, csum_r, tx_data_r;
  logic protect_enable_r, hold_full_r, tx_valid_r, ftc_r, mask_r;
  logic chk_dis_r, chk_cls_r, slot_off_r;
  logic [3:0] total_r, wr_cnt_r, sent_cnt_r;
  logic [15:0] bit_cnt_r, slot_cnt_r, slot_len_r;

  // ****************************************
  // bus decode
  // ****************************************
  wire addr_ph = hsel_in && htrans_in[1] && hready_in;
  wire wr_ctrl = a_wr_r && a_addr_r == lmfc_pkg::OFS_CTRL;
  wire wr_mode = a_wr_r && a_addr_r == lmfc_pkg::OFS_MODE && !protect_enable_r;
  wire wr_ident = a_wr_r && a_addr_r == lmfc_pkg::OFS_IDENT;
  wire wr_hold = a_wr_r && a_addr_r == lmfc_pkg::OFS_HOLD;
  wire wr_stat = a_wr_r && a_addr_r == lmfc_pkg::OFS_STAT;
  wire wr_mask = a_wr_r && a_addr_r == lmfc_pkg::OFS_MASK;
  wire wr_baud = a_wr_r && a_addr_r == lmfc_pkg::OFS_BAUD && !protect_enable_r;
  wire wr_rto = a_wr_r && a_addr_r == lmfc_pkg::OFS_RTO && !protect_enable_r;
  wire wr_ttg = a_wr_r && a_addr_r == lmfc_pkg::OFS_TTG && !protect_enable_r;
  wire wr_prot = a_wr_r && a_addr_r == lmfc_pkg::OFS_PROT;
  wire key_ok = hwdata_in[31:8] == lmfc_pkg::WP_KEY;

  // ****************************************
  // frame control
  // ****************************************
  wire idle = st_r == lmfc_pkg::ST_IDLE;
  wire in_frame = st_r == lmfc_pkg::ST_HDR || st_r == lmfc_pkg::ST_DATA;
  wire tx_fire = tx_valid_r && tx_ready_in;
  wire tx_free = !tx_valid_r || tx_ready_in;
  wire tx_rdy = idle || (in_frame && !hold_full_r && wr_cnt_r < total_r);
  wire start = wr_ident && idle;
  wire hold_take = wr_hold && tx_rdy && in_frame;
  wire data_go = st_r == lmfc_pkg::ST_DATA && hold_full_r && tx_free;
  wire data_done = st_r == lmfc_pkg::ST_DATA && !hold_full_r && sent_cnt_r == total_r && tx_free;
  wire csum_go = data_done && !chk_dis_r;
  wire ftc_set = (data_done && chk_dis_r) || (st_r == lmfc_pkg::ST_CSUM && tx_fire);
  wire slot_done = slot_cnt_r >= slot_len_r;
  wire bit_tick = bit_cnt_r + 16'h0001 >= baud_r;
  wire [3:0] resp_len = mode_r.response_length_mode ? id_len(hwdata_in[5:4]) :
                        {1'b0, mode_r.fixed_len_m1} + 4'h1;
  wire [3:0] total_nxt = resp_len + {3'h0, mode_r.checksum_disable};
  wire [7:0] csum_init = mode_r.checksum_type_select ? 8'h00 : hwdata_in[7:0];

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      lmfc_pkg::ST_IDLE: begin
        if (start && tx_free) begin
          st_nxt = lmfc_pkg::ST_HDR;
        end
      end
      lmfc_pkg::ST_HDR: begin
        if (tx_fire) begin
          st_nxt = lmfc_pkg::ST_DATA;
        end
      end
      lmfc_pkg::ST_DATA: begin
        if (csum_go) begin
          st_nxt = lmfc_pkg::ST_CSUM;
        end else if (ftc_set) begin
          st_nxt = slot_off_r ? lmfc_pkg::ST_IDLE : lmfc_pkg::ST_SLOT;
        end
      end
      lmfc_pkg::ST_CSUM: begin
        if (ftc_set) begin
          st_nxt = slot_off_r ? lmfc_pkg::ST_IDLE : lmfc_pkg::ST_SLOT;
        end
      end
      lmfc_pkg::ST_SLOT: begin
        if (slot_done) begin
          st_nxt = lmfc_pkg::ST_IDLE;
        end
      end
      default: st_nxt = lmfc_pkg::ST_IDLE;
    endcase
  end

  // ****************************************
  // read mux
  // ****************************************
  wire [7:0] ra = haddr_in[7:0];
  wire [31:0] rd_mux =
    ra == lmfc_pkg::OFS_MODE ? {24'h000000, mode_r} :
    ra == lmfc_pkg::OFS_IDENT ? {24'h000000, id_r} :
    ra == lmfc_pkg::OFS_STAT ? {30'h0000000, ftc_r, tx_rdy} :
    ra == lmfc_pkg::OFS_MASK ? {30'h0000000, mask_r, 1'b0} :
    ra == lmfc_pkg::OFS_BAUD ? {16'h0000, baud_r} :
    ra == lmfc_pkg::OFS_RTO ? {16'h0000, rto_r} :
    ra == lmfc_pkg::OFS_TTG ? {24'h000000, ttg_r} :
    ra == lmfc_pkg::OFS_PROT ? {31'h0000000, protect_enable_r} : 32'h00000000;

  // ****************************************
  // bus and configuration registers
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      a_wr_r <= 1'b0;
      a_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      a_wr_r <= addr_ph && hwrite_in;
      a_addr_r <= haddr_in[7:0];
      if (addr_ph && !hwrite_in) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      mode_r <= lmfc_pkg::MODE_RST;
      baud_r <= lmfc_pkg::BAUD_RST;
      rto_r <= lmfc_pkg::RTO_RST;
      ttg_r <= lmfc_pkg::TTG_RST;
      protect_enable_r <= 1'b0;
      mask_r <= 1'b0;
    end else begin
      if (wr_mode) mode_r <= hwdata_in[7:0];
      if (wr_baud) baud_r <= hwdata_in[15:0];
      if (wr_rto) rto_r <= hwdata_in[15:0];
      if (wr_ttg) ttg_r <= hwdata_in[7:0];
      if (wr_prot && key_ok) protect_enable_r <= hwdata_in[0];
      if (wr_mask) mask_r <= hwdata_in[lmfc_pkg::STAT_FTC_BIT];
    end
  end

  // ****************************************
  // frame engine registers
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      st_r <= lmfc_pkg::ST_IDLE;
      id_r <= 8'h00;
      csum_r <= 8'h00;
      total_r <= 4'h0;
      chk_dis_r <= 1'b0;
      chk_cls_r <= 1'b0;
      slot_off_r <= 1'b0;
      slot_len_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      if (start && tx_free) begin
        id_r <= hwdata_in[7:0];
        csum_r <= csum_init;
        total_r <= total_nxt;
        chk_dis_r <= mode_r.checksum_disable;
        chk_cls_r <= mode_r.checksum_type_select;
        slot_off_r <= mode_r.frame_slot_disable;
        slot_len_r <= slot_bits(resp_len);
      end else if (data_go) begin
        csum_r <= csum_add(csum_r, hold_r);
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      hold_r <= 8'h00;
      hold_full_r <= 1'b0;
      wr_cnt_r <= 4'h0;
      sent_cnt_r <= 4'h0;
    end else begin
      if (start) begin
        wr_cnt_r <= 4'h0;
        sent_cnt_r <= 4'h0;
      end else begin
        if (hold_take) wr_cnt_r <= wr_cnt_r + 4'h1;
        if (data_go) sent_cnt_r <= sent_cnt_r + 4'h1;
      end
      if (hold_take) begin
        hold_r <= hwdata_in[7:0];
        hold_full_r <= 1'b1;
      end else if (data_go) begin
        hold_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      tx_data_r <= 8'h00;
      tx_valid_r <= 1'b0;
    end else begin
      if (start && tx_free) begin
        tx_data_r <= hwdata_in[7:0];
        tx_valid_r <= 1'b1;
      end else if (data_go) begin
        tx_data_r <= hold_r;
        tx_valid_r <= 1'b1;
      end else if (csum_go) begin
        tx_data_r <= ~csum_r;
        tx_valid_r <= 1'b1;
      end else if (tx_fire) begin
        tx_valid_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // bit timer, slot counter, status
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      bit_cnt_r <= 16'h0000;
      slot_cnt_r <= 16'h0000;
      ftc_r <= 1'b0;
    end else begin
      bit_cnt_r <= (bit_tick || start) ? 16'h0000 : bit_cnt_r + 16'h0001;
      if (start) begin
        slot_cnt_r <= 16'h0000;
      end else if (bit_tick && !idle && !slot_done) begin
        slot_cnt_r <= slot_cnt_r + 16'h0001;
      end
      ftc_r <= ftc_set || (ftc_r && !(wr_ctrl && hwdata_in[lmfc_pkg::CTRL_CLR_BIT]) &&
               !(wr_stat && hwdata_in[lmfc_pkg::STAT_FTC_BIT]));
    end
  end

  assign hrdata_out = hrdata_r;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign tx_data_out = tx_data_r;
  assign tx_valid_out = tx_valid_r;
  assign transmit_ready_out = tx_rdy;
  assign irq_out = ftc_r && mask_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  len_decode_a: assert property (start && tx_free && mode_r.response_length_mode && !mode_r.checksum_disable
    |=> total_r == id_len(id_r[5:4])) else $error("response length wrong");
  csum_fold_a: assert property (csum_go |=> tx_valid_out && tx_data_out == ~$past(csum_r))
    else $error("checksum byte wrong");
  classic_a: assert property (start && tx_free && mode_r.checksum_type_select |=> csum_r == 8'h00)
    else $error("classic seed wrong");
  enhanced_a: assert property (start && tx_free && !mode_r.checksum_type_select |=> csum_r == id_r)
    else $error("enhanced seed wrong");
  no_csum_a: assert property (chk_dis_r |-> st_r != lmfc_pkg::ST_CSUM)
    else $error("checksum sent while disabled");
  last_rdy_a: assert property (in_frame && wr_cnt_r == total_r |-> !transmit_ready_out)
    else $error("ready after last byte");
  slot_skip_a: assert property (ftc_set && slot_off_r |=> st_r == lmfc_pkg::ST_IDLE)
    else $error("slot applied while disabled");
  slot_hold_a: assert property (st_r == lmfc_pkg::ST_SLOT ##1 st_r == lmfc_pkg::ST_IDLE
    |-> $past(slot_cnt_r) >= slot_len_r && !$past(transmit_ready_out)) else $error("slot left early");
  ftc_early_a: assert property (ftc_set |=> ftc_r) else $error("complete flag late");
  stat_reset_a: assert property (wr_ctrl && hwdata_in[0] && !ftc_set |=> !ftc_r)
    else $error("status reset ignored");
  flag_clear_a: assert property (wr_stat && hwdata_in[lmfc_pkg::STAT_FTC_BIT] && !ftc_set |=> !ftc_r)
    else $error("flag write clear ignored");
  slot_len_a: assert property (start && tx_free |=> slot_len_r >= 16'h004C && slot_len_r <= 16'h00AE)
    else $error("slot length out of range");
  key_a: assert property (wr_prot && !key_ok |=> $stable(protect_enable_r)) else $error("key bypassed");
  prot_a: assert property (protect_enable_r && a_wr_r && a_addr_r == lmfc_pkg::OFS_BAUD |=> $stable(baud_r))
    else $error("protected write taken");
  mode_lock_a: assert property (protect_enable_r && a_wr_r && a_addr_r == lmfc_pkg::OFS_MODE |=> $stable(mode_r))
    else $error("protected mode write taken");

  frame_cv: cover property (csum_go ##[1:50] ftc_set);
  slot_cv: cover property (st_r == lmfc_pkg::ST_SLOT ##1 st_r == lmfc_pkg::ST_IDLE);
  unlock_cv: cover property (wr_prot && key_ok ##1 protect_enable_r);
  fixed_cv: cover property (start && tx_free && !mode_r.response_length_mode);
endmodule
`default_nettype wire

// [core/lmfc_pkg.sv]
// constants and types for the lin master frame and checksum block
package lmfc_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_IDENT = 8'h08;
  localparam logic [7:0] OFS_HOLD = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_BAUD = 8'h20;
  localparam logic [7:0] OFS_RTO = 8'h24;
  localparam logic [7:0] OFS_TTG = 8'h28;
  localparam logic [7:0] OFS_PROT = 8'hE4;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRL_CLR_BIT = 0;
  localparam int STAT_RDY_BIT = 0;
  localparam int STAT_FTC_BIT = 1;
  localparam logic [23:0] WP_KEY = 24'h555341;
  localparam logic [15:0] BAUD_RST = 16'h0010;
  localparam logic [15:0] RTO_RST = 16'h0000;
  localparam logic [7:0] TTG_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  // ****************************************
  // frame timing in bit periods
  // ****************************************
  localparam logic [15:0] HDR_BITS = 16'h0022;
  localparam logic [15:0] BYTE_BITS = 16'h000A;
  localparam logic [15:0] SLOT_NUM = 16'h000E;
  localparam logic [15:0] SLOT_DEN = 16'h000A;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic spare;
    logic [2:0] fixed_len_m1;
    logic frame_slot_disable;
    logic checksum_disable;
    logic checksum_type_select;
    logic response_length_mode;
  } lmfc_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HDR = 3'h1,
    ST_DATA = 3'h3,
    ST_CSUM = 3'h2,
    ST_SLOT = 3'h6
  } lmfc_state_t;
endpackage

// [sim/lmfc_byte_sink.sv]
// line shifter model that takes bytes with random stalls
`timescale 1ns/1ps
`default_nettype none
module lmfc_byte_sink (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // byte stream
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  logic [7:0] got[$];
  initial tx_ready_out = 1'b0;
  always @(posedge mclk_in) begin
    if (rstn_in && tx_valid_in && tx_ready_out) begin
      got.push_back(tx_data_in);
    end
    tx_ready_out <= rstn_in && ($urandom_range(0, 3) != 0);
  end
endmodule
`default_nettype wire

// [sim/lin_master_frame_checksum_tb_top.sv]
// self-checking bench for the lin master frame and checksum block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module lin_master_frame_checksum_tb_top;
  logic mclk_in, rstn_in, hsel, hwrite, hrdy, hresp, tx_valid, tx_ready, transmit_ready_out, irq_out;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [7:0] tx_data;
  logic [7:0] regs[6] = '{8'h04, 8'h20, 8'h24, 8'h28, 8'hE4, 8'h40};
  logic [31:0] rstv[6] = '{32'h0, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0};
  int error_cnt = 0;
  int checked = 0;
  int i;
  lmfc_top lmfc_top_inst (.mclk_in(mclk_in), .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .tx_data_out(tx_data),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .transmit_ready_out(transmit_ready_out),
    .irq_out(irq_out));
  lmfc_byte_sink lmfc_byte_sink_inst (.mclk_in(mclk_in), .rstn_in(rstn_in), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));
  // ****************************************
  // bus tasks and expectations
  // ****************************************
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge mclk_in);
    while (hrdy !== 1'b1) begin
      @(posedge mclk_in);
    end
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk_in);
    while (hrdy !== 1'b1) begin
      @(posedge mclk_in);
    end
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    ahb(1'b1, a, v, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    ahb(1'b0, a, 32'h0, v);
  endtask
  task automatic wait_tx();
    int n;
    n = 0;
    // ready is judged by the state left by the previous edge
    @(posedge mclk_in);
    while (transmit_ready_out !== 1'b1 && n < 2000) begin
      n++;
      @(posedge mclk_in);
    end
    `CHK(transmit_ready_out, 1'b1)
  endtask
  function automatic logic [7:0] add(input logic [7:0] s, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, s} + {1'b0, b};
    return t[7:0] + {7'h0, t[8]};
  endfunction
  // md is {fixed length minus one, slot disable, checksum disable, classic, length mode}
  task automatic frame(input logic [6:0] md, input logic [7:0] id);
    int n, k, sl;
    logic [7:0] s, b;
    logic [7:0] exp[$];
    time t0;
    n = !md[0] ? int'(md[6:4]) + 1 : (id[5:4] == 2'h3) ? 8 : (id[5:4] == 2'h2) ? 4 : 2;
    sl = (14 * (34 + 10 * (n + 1)) + 9) / 10;
    s = md[1] ? 8'h00 : id;
    exp = '{id};
    lmfc_byte_sink_inst.got.delete();
    wr(lmfc_pkg::OFS_MODE, {25'h0, md});
    t0 = $time;
    wr(lmfc_pkg::OFS_IDENT, {24'h0, id});
    for (k = 0; k < n + int'(md[2]); k++) begin
      b = (k == n) ? ~s : 8'($urandom);
      if (k < n) s = add(s, b);
      exp.push_back(b);
      wait_tx();
      wr(lmfc_pkg::OFS_HOLD, {24'h0, b});
    end
    #1;
    if (!md[2]) begin
      `CHK(transmit_ready_out, 1'b0)
      exp.push_back(~s);
    end
    d = 32'h0;
    for (k = 0; k < 400 && d[1] !== 1'b1; k++) rd(lmfc_pkg::OFS_STAT, d);
    `CHK(d[1], 1'b1)
    if (!md[3]) `CHK(transmit_ready_out, 1'b0)
    `CHK(irq_out, 1'b1)
    wr(lmfc_pkg::OFS_MASK, 32'h0);
    #1;
    `CHK(irq_out, 1'b0)
    wr(lmfc_pkg::OFS_MASK, 32'h2);
    wait_tx();
    if (!md[3]) `CHK(($time - t0) / 50 >= 2 * sl + 4, 1'b1)
    `CHK(lmfc_byte_sink_inst.got.size(), exp.size())
    for (k = 0; k < exp.size(); k++) `CHK(lmfc_byte_sink_inst.got[k], exp[k])
    if (id[0]) wr(lmfc_pkg::OFS_CTRL, 32'h1);
    else wr(lmfc_pkg::OFS_STAT, 32'h2);
    rd(lmfc_pkg::OFS_STAT, d);
    `CHK(d[1], 1'b0)
    `CHK(irq_out, 1'b0)
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************************************
  // clock, watchdog and test sequence
  // ****************************************
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  initial begin
    #3000000;
    error_cnt++;
    complete_run();
  end
  initial begin
    rstn_in = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    void'($urandom(26));
    repeat (2) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(posedge mclk_in);
    `CHK(transmit_ready_out, 1'b1)
    `CHK(irq_out, 1'b0)
    for (i = 0; i < 6; i++) begin
      rd(regs[i], d);
      `CHK(d, rstv[i])
    end
    wr(lmfc_pkg::OFS_PROT, {24'h555340, 8'h01});
    rd(lmfc_pkg::OFS_PROT, d);
    `CHK(d, 32'h0)
    wr(lmfc_pkg::OFS_PROT, {lmfc_pkg::WP_KEY, 8'h01});
    rd(lmfc_pkg::OFS_PROT, d);
    `CHK(d, 32'h1)
    for (i = 0; i < 4; i++) begin
      wr(regs[i], {24'h0, 8'($urandom) | 8'h01});
      rd(regs[i], d);
      `CHK(d, rstv[i])
      `CHK(hresp, 1'b0)
    end
    wr(lmfc_pkg::OFS_PROT, {lmfc_pkg::WP_KEY, 8'h00});
    wr(lmfc_pkg::OFS_BAUD, 32'h2);
    wr(lmfc_pkg::OFS_TTG, 32'h5A);
    rd(lmfc_pkg::OFS_BAUD, d);
    `CHK(d, 32'h2)
    rd(lmfc_pkg::OFS_TTG, d);
    `CHK(d, 32'h5A)
    wr(lmfc_pkg::OFS_MASK, 32'h2);
    for (i = 0; i < 8; i++) begin
      frame({3'($urandom), 1'(i > 3), 1'(i % 3 == 2), 1'(i % 2), 1'(i % 5 != 1)}, {2'($urandom), 2'(i), 4'($urandom)});
    end
    complete_run();
  end
endmodule
`default_nettype wire
